// ==== bench/rf_measure_dac_control_test.sv ====
/* Self-checking bench of rfmdc_top with the controller model.
   Assumes design, monitor and model files compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "rfmdc_regs.vh"
`define CHECK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module rf_measure_dac_control_test;
    localparam logic [1:0] TX = `RFMDC_MODE_TRANSMIT;
    localparam logic [1:0] RX = `RFMDC_MODE_RECEIVE;
    logic clk;
    logic rst = 1'b1;
    logic cdone = 1'b0;
    logic cmp = 1'b0;
    logic [7:0] cdata = 8'h00;
    logic [7:0] rd;
    int bad_count = 0;
    int num_checks = 0;
    logic [3:0] en_tab [4] = '{4'h0, 4'hf, 4'h5, 4'h9};
    wire logic cs_n, sclk, sdi, sdo, sdo_oe, mwin, mctl, dwin, dctl;
    wire logic [5:0] vcxo, pa;
    wire logic [6:0] upc, modg;
    wire logic [3:0] en;
    wire logic [1:0] mode;
    wire logic [2:0] mux, gain;
    wire logic sdg_n, best_antenna_out, path, amp, bias, peak, cstart, dch, cpwr;

    rfmdc_top u_dut (.core_clk_i(clk), .rst_i(rst), .chip_select_n_i(cs_n), .serial_clk_i(sclk),
        .serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_o(sdo_oe), .measure_window_in_i(mwin),
        .measure_control_in_i(mctl), .diversity_window_in_i(dwin), .diversity_control_in_i(dctl),
        .conv_data_i(cdata), .conv_done_i(cdone), .compare_second_greater_i(cmp), .vcxo_tune_dac_o(vcxo),
        .upconv_gain_dac_o(upc), .modulator_gain_dac_o(modg), .pa_bias_dac_o(pa), .dac_enable_o(en),
        .power_mode_o(mode), .bias_gen_shutdown_out_n_o(sdg_n), .best_antenna_out_o(best_antenna_out),
        .sense_path_power_o(path), .sense_amp_enable_o(amp), .sense_bias_out_o(bias), .sense_mux_sel_o(mux),
        .sense_gain_sel_o(gain), .peak_track_o(peak), .conv_start_o(cstart), .direct_channel_o(dch),
        .converter_power_o(cpwr), .diversity_circuit_power_o(), .acquire_first_o(), .acquire_second_o());
    rfmdc_ctrl_model u_ctrl (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk),
        .sdi_o(sdi), .mwin_o(mwin), .mctl_o(mctl), .dwin_o(dwin), .dctl_o(dctl));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [1:0] md, input logic sd, input logic ld,
                      input logic [7:0] d);
        u_ctrl.frame({a, md, sd, ld}, d, 1'b1, 0, rd);
    endtask

    // Window pulse, conversion answer, then read-back of the result
    task automatic measure(input logic [2:0] emux, input logic [2:0] egain, input logic tx, input logic [7:0] v);
        int n;
        u_ctrl.strobe(1'b1, 1'b1);
        repeat (10) @(negedge clk);
        `CHECK("path", 1'b1, path)
        `CHECK("amp", tx, amp)
        `CHECK("bias", tx, bias)
        `CHECK("mux", emux, mux)
        `CHECK("gain", egain, gain)
        `CHECK("peak", 1'b1, peak)
        `CHECK("cpwr", 1'b1, cpwr)
        u_ctrl.strobe(1'b0, 1'b1);
        for (n = 0; n < 20 && cstart !== 1'b1; n++) @(negedge clk);
        `CHECK("conv_start", 1'b1, cstart)
        @(negedge clk);
        cdone = 1'b1;
        cdata = v;
        @(negedge clk);
        cdone = 1'b0;
        repeat (2) @(negedge clk);
        `CHECK("peak_off", 1'b0, peak)
        `CHECK("bias_off", 1'b0, bias)
        u_ctrl.strobe(1'b0, 1'b0);
        wr(`RFMDC_ADDR_CONV_RESULT, tx ? TX : RX, 1'b1, 1'b0, 8'h00);
        `CHECK("adc", v, rd)
    endtask

    initial begin
        int m;
        logic fr;
        logic [1:0] cls;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        `CHECK("vcxo", 6'h00, vcxo)
        `CHECK("upc", 7'h00, upc)
        `CHECK("en", 4'h0, en)
        `CHECK("best_antenna_out", 1'b0, best_antenna_out)
        $display("test reset done");
        wr(3'h0, 2'h0, 1'b1, 1'b0, 8'hff);
        wr(3'h1, 2'h0, 1'b1, 1'b0, 8'h85);
        wr(3'h2, 2'h0, 1'b1, 1'b0, 8'h9a);
        u_ctrl.frame({3'h3, 2'h0, 1'b1, 1'b0}, 8'h6b, 1'b1, 300, rd);
        `CHECK("vcxo_pre", 6'h00, vcxo)
        wr(3'h4, TX, 1'b1, 1'b1, 8'hff);
        `CHECK("vcxo", 6'h3f, vcxo)
        `CHECK("upc", 7'h05, upc)
        `CHECK("modg", 7'h1a, modg)
        `CHECK("dch", 1'b1, dch)
        `CHECK("pa", 6'h2b, pa)
        `CHECK("sdg", 1'b1, sdg_n)
        $display("test preload done");
        for (m = 0; m < 4; m++) begin
            wr(3'h5, m[1:0], 1'b1, 1'b1, 8'h00);
            `CHECK("mode", m[1:0], mode)
            `CHECK("en", en_tab[m], en)
            `CHECK("vcxo", (m == 0) ? 6'h00 : 6'h3f, vcxo)
            `CHECK("upc", (m == 1) ? 7'h05 : 7'h00, upc)
        end
        $display("test modes done");
        wr(3'h6, TX, 1'b0, 1'b1, 8'h00);
        `CHECK("sdg", 1'b0, sdg_n)
        `CHECK("en", 4'h7, en)
        `CHECK("pa", 6'h00, pa)
        u_ctrl.frame({3'h0, TX, 1'b1, 1'b1}, 8'h00, 1'b0, 0, rd);
        `CHECK("sdg", 1'b0, sdg_n)
        `CHECK("vcxo", 6'h3f, vcxo)
        $display("test shutdown bit done");
        for (m = 0; m < 4; m++) begin
            fr = (m < 2);
            cls = m[0] ? m[1:0] : 2'h0;
            wr(3'h1, TX, 1'b1, 1'b0, {fr, 7'h11});
            wr(3'h3, TX, 1'b1, 1'b0, {cls, 6'h2a});
            wr(3'h2, TX, 1'b1, 1'b1, 8'h1a);
            measure(!fr ? 3'h1 : (cls == 2'h0 ? 3'h2 : 3'h4),
                    fr ? 3'h1 : (cls == 2'h0 ? 3'h2 : 3'h4), 1'b1, 8'h81 + 8'(m));
        end
        $display("test power sense done");
        wr(3'h2, RX, 1'b1, 1'b1, 8'h1a);
        `CHECK("dch", 1'b0, dch)
        measure(3'h0, 3'h4, 1'b0, 8'h3c);
        $display("test receive done");
        for (m = 0; m < 3; m++) begin
            cmp = ~m[0];
            u_ctrl.diversity();
            `CHECK("best_antenna_out", ~m[0], best_antenna_out)
        end
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        `CHECK("best_antenna_out_rst", 1'b0, best_antenna_out)
        `CHECK("vcxo_rst", 6'h00, vcxo)
        $display("test diversity done");
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule

bind rfmdc_top rfmdc_monitor u_mon (.*);
`default_nettype wire

// ==== bench/rfmdc_ctrl_model.sv ====
/* Controller model: drives the link and strobe pins.
   Assumes the core clock of the bench; changes pins at its falling edge. */
`timescale 1ns/1ns
`default_nettype none
module rfmdc_ctrl_model (
    // Clock and data out of the device
    input wire logic clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    // Driven pins
    output var logic cs_n_o,
    output var logic sclk_o,
    output var logic sdi_o,
    output var logic mwin_o,
    output var logic mctl_o,
    output var logic dwin_o,
    output var logic dctl_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        mwin_o = 1'b0;
        mctl_o = 1'b0;
        dwin_o = 1'b0;
        dctl_o = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic strobe(input logic w, input logic c);
        mwin_o = w;
        mctl_o = c;
    endtask

    // Start bit, command, data; optional stall with the clock stopped
    task automatic frame(input logic [6:0] cmd, input logic [7:0] dat, input logic sel, input int stall,
                         output logic [7:0] rd);
        logic [15:0] bits;
        int i;
        bits = {1'b1, cmd, dat};
        rd = 8'h00;
        cs_n_o = ~sel;
        wait_n(4);
        for (i = 0; i < 16; i++) begin
            sdi_o = bits[15 - i];
            wait_n(4);
            if (i > 8) rd[16 - i] = sdo_oe_i ? sdo_i : 1'bx;
            sclk_o = 1'b1;
            wait_n(4);
            sclk_o = 1'b0;
            if (i == 7) wait_n(stall);
        end
        wait_n(4);
        rd[0] = sdo_oe_i ? sdo_i : 1'bx;
        sdi_o = 1'b0;
        cs_n_o = 1'b1;
        wait_n(12);
    endtask

    // Control low 4, high 8, low 4, high 8 clocks in the window
    task automatic diversity();
        int k;
        dwin_o = 1'b1;
        wait_n(4);
        for (k = 0; k < 25; k++) begin
            if (k == 24) dwin_o = 1'b0;
            if (k < 24) dctl_o = (k >= 4 && k < 12) || k >= 16;
            sclk_o = 1'b1;
            wait_n(4);
            sclk_o = 1'b0;
            wait_n(4);
        end
        dctl_o = 1'b0;
        wait_n(12);
    endtask
endmodule
`default_nettype wire

// ==== bench/rfmdc_monitor.sv ====
/* Port checker of rfmdc_top.
   Assumes binding into rfmdc_top; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
`include "rfmdc_regs.vh"
module rfmdc_monitor (
    // Clock, reset and strobes
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic measure_window_in_i,
    input wire logic diversity_window_in_i,
    input wire logic compare_second_greater_i,
    // Watched outputs
    input wire logic serial_data_oe_o,
    input wire logic [3:0] dac_enable_o,
    input wire logic [1:0] power_mode_o,
    input wire logic best_antenna_out_o,
    input wire logic sense_path_power_o,
    input wire logic sense_amp_enable_o,
    input wire logic sense_bias_out_o,
    input wire logic [2:0] sense_mux_sel_o,
    input wire logic [2:0] sense_gain_sel_o,
    input wire logic peak_track_o,
    input wire logic conv_start_o,
    input wire logic diversity_circuit_power_o,
    input wire logic acquire_first_o,
    input wire logic acquire_second_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_OE_OFF: assert property (chip_select_n_i [*8] |-> !serial_data_oe_o)
        else $error("data out enabled while deselected");
    AST_BIAS_TX: assert property (sense_bias_out_o |->
        sense_amp_enable_o && sense_path_power_o && power_mode_o == `RFMDC_MODE_TRANSMIT)
        else $error("sense bias outside transmit measurement");
    AST_MUX_ONE: assert property (sense_amp_enable_o && $past(sense_amp_enable_o) |-> $onehot(sense_mux_sel_o))
        else $error("sense mux not one-hot");
    AST_GAIN: assert property ($onehot(sense_gain_sel_o))
        else $error("gain select not one-hot");
    AST_CONV: assert property (conv_start_o |-> !measure_window_in_i ##1 !conv_start_o ##[0:1] !peak_track_o)
        else $error("conversion start or peak release wrong");
    AST_BEST_ANTENNA_OUT: assert property ($changed(best_antenna_out_o) |->
        !diversity_window_in_i && best_antenna_out_o == $past(compare_second_greater_i))
        else $error("best antenna changed wrongly");
    AST_DIV_PWR: assert property (diversity_window_in_i [*8] |-> diversity_circuit_power_o)
        else $error("diversity circuit unpowered in window");
    AST_ACQ: assert property (!(acquire_first_o && acquire_second_o))
        else $error("both antenna periods acquiring");
    AST_DAC_EN: assert property (power_mode_o == `RFMDC_MODE_SHUTDOWN && $past(power_mode_o) == 2'h0 |->
        dac_enable_o == 4'h0)
        else $error("dac enabled in shutdown");

    // Main scenarios reached
    cover property (conv_start_o);
    cover property ($rose(best_antenna_out_o));
    cover property ($rose(acquire_second_o));
endmodule
`default_nettype wire

// ==== hw/rfmdc_top.v ====
/*
 * Digital control of the rf measure / DAC chip: serial command link
 * sampled on the core clock, DAC input and active registers, power
 * mode decode, power-sense path control and antenna-diversity latch.
 * Assumes: all link and strobe pins come from outside the core clock
 * domain; the converter and comparator answers come from same-clock
 * analog models.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rfmdc_regs.vh"

// Summary of operation
// - Best antenna output is 0 if first period stronger, 1 if second.
// - First antenna period spans first 12 serial clocks after window rises.
// - Serial data output is driven only while chip select is low.
// - Serial link reacts to clock and data only with chip select low.
// - Serial clock may stop and restart anytime without losing state.
// - Sense bias is on only during a transmit power-sense measurement.
// - Measure window feeds peak detector in tx or rx; converter samples at window end.
// - Sense mux routes exactly one of reverse, forward class1, class2-4 in a transmit measurement; otherwise none.
// - Gain: forward, reverse class 1, reverse classes 2-4 selected.
// - Peak detector tracks and holds until a conversion starts.
// - Address 000 loads the 6-bit tuning code; bits 7:6 ignored.
// - Address 001 loads 7-bit upconverter code; bit 7 selects direction.
// - Address 010 loads 7-bit modulator code; bit 7 selects channel.
// - Address 011 loads 6-bit bias code; bits 7:6 power class.
// - Address 111 read returns the 8-bit conversion result, MSB first.
// - Measure window powers sense path in tx or rx; gain amp tx only.
// - Diversity window powers diversity circuit; result latch resets low.
// - Diversity window fall latches comparator into best antenna output.
// - All DAC outputs are zero after reset.
// - Load bit moves all input registers to active ones after frame.
// - Receive/transmit bits select shutdown, transmit, receive, standby.
// - First 1 after chip select falls starts a 16-bit frame.
// - Cleared shutdown bit drives bias shutdown low, disables bias DAC.
module rfmdc_top (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // Serial link pins
    input wire chip_select_n_i,
    input wire serial_clk_i,
    input wire serial_data_i,
    output reg serial_data_o,
    output reg serial_data_oe_o,
    // Measurement and diversity strobes
    input wire measure_window_in_i,
    input wire measure_control_in_i,
    input wire diversity_window_in_i,
    input wire diversity_control_in_i,
    // Converter and comparator answers
    input wire [7:0] conv_data_i,
    input wire conv_done_i,
    input wire compare_second_greater_i,
    // DAC codes and enables
    output reg [5:0] vcxo_tune_dac_o,
    output reg [6:0] upconv_gain_dac_o,
    output reg [6:0] modulator_gain_dac_o,
    output reg [5:0] pa_bias_dac_o,
    output reg [3:0] dac_enable_o,
    // Power mode and digital outputs
    output reg [1:0] power_mode_o,
    output reg bias_gen_shutdown_out_n_o,
    output reg best_antenna_out_o,
    // Power-sense path control
    output reg sense_path_power_o,
    output reg sense_amp_enable_o,
    output reg sense_bias_out_o,
    output reg [2:0] sense_mux_sel_o,
    output reg [2:0] sense_gain_sel_o,
    output reg peak_track_o,
    output reg conv_start_o,
    output reg direct_channel_o,
    output reg converter_power_o,
    // Diversity circuit control
    output reg diversity_circuit_power_o,
    output reg acquire_first_o,
    output reg acquire_second_o
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
localparam NSYNC = 7;
wire [NSYNC-1:0] raw_in;
reg [NSYNC-1:0] sync1;
reg [NSYNC-1:0] sync2;
reg [NSYNC-1:0] sync3;
reg [NSYNC-1:0] stab;
reg [NSYNC-1:0] stab_d;
wire [NSYNC-1:0] agree;

assign raw_in = {diversity_control_in_i, diversity_window_in_i, measure_control_in_i,
                 measure_window_in_i, serial_data_i, serial_clk_i, chip_select_n_i};
assign agree = ~(sync2 ^ sync3);

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sync1 <= {NSYNC{1'b0}};
        sync2 <= {NSYNC{1'b0}};
        sync3 <= {NSYNC{1'b0}};
        stab <= {{(NSYNC-1){1'b0}}, 1'b1};
        stab_d <= {{(NSYNC-1){1'b0}}, 1'b1};
    end else begin
        sync1 <= raw_in;
        sync2 <= sync1;
        sync3 <= sync2;
        // A change counts once the second and third stage agree
        stab <= (agree & sync3) | (~agree & stab);
        stab_d <= stab;
    end
end

wire cs_n = stab[0];
wire sclk = stab[1];
wire din = stab_d[2]; // Value before the falling edge: zero hold time
wire mwin = stab[3];
wire mctl = stab[4];
wire dwin = stab[5];
wire dctl = stab[6];
wire sclk_fall = stab_d[1] & ~sclk;
wire sclk_rise = ~stab_d[1] & sclk;
wire mwin_fall = stab_d[3] & ~mwin;
wire dwin_rise = ~stab_d[5] & dwin;
wire dwin_fall = stab_d[5] & ~dwin;

// ----------------------------------------------------------------
// Serial frame receiver
// ----------------------------------------------------------------
localparam ST_IDLE = 3'h1;
localparam ST_CMD = 3'h2;
localparam ST_DATA = 3'h4;

reg [2:0] state;
reg [3:0] bit_cnt;
reg [6:0] cmd;
reg [7:0] data;
reg [7:0] out_shift;
reg frame_done;
reg [7:0] conversion_result;

wire [2:0] cmd_addr = cmd[`RFMDC_CMD_ADDR_MSB:`RFMDC_CMD_ADDR_LSB];
wire is_read = (cmd_addr == `RFMDC_ADDR_CONV_RESULT);

// Edge-driven only, so a stopped serial clock just freezes the frame
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        cmd <= 7'h00;
        data <= `RFMDC_RST_BYTE;
        out_shift <= `RFMDC_RST_BYTE;
        frame_done <= 1'b0;
    end else begin
        frame_done <= 1'b0;
        if (cs_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (sclk_fall && din) begin
                        state <= ST_CMD;
                        cmd <= 7'h00;
                        data <= `RFMDC_RST_BYTE;
                        bit_cnt <= 4'h0;
                    end
                end
                ST_CMD: begin
                    if (sclk_fall) begin
                        cmd <= {cmd[5:0], din};
                        if (bit_cnt == `RFMDC_CMD_BITS - 4'h1) begin
                            state <= ST_DATA;
                            bit_cnt <= 4'h0;
                            out_shift <= conversion_result;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_fall) begin
                        data <= {data[6:0], din};
                        if (bit_cnt == `RFMDC_DATA_BITS - 4'h1) begin
                            state <= ST_IDLE;
                            bit_cnt <= 4'h0;
                            frame_done <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end else if (sclk_rise && is_read) begin
                        out_shift <= {out_shift[6:0], 1'b0};
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

// Read data leaves on rising serial clock edges, MSB first
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        serial_data_o <= 1'b0;
        serial_data_oe_o <= 1'b0;
    end else begin
        serial_data_oe_o <= ~cs_n;
        if (cs_n) begin
            serial_data_o <= 1'b0;
        end else if (state == ST_DATA && is_read && sclk_rise) begin
            serial_data_o <= out_shift[7];
        end
    end
end

// ----------------------------------------------------------------
// Input and active registers
// ----------------------------------------------------------------
reg [5:0] vcxo_in;
reg [6:0] upconv_in;
reg [6:0] mod_in;
reg [5:0] bias_in;
reg forward_in;
reg direct_in;
reg [1:0] class_in;
reg [1:0] mode_in;
reg sd_in;
reg load_pend;
reg forward_act;
reg [1:0] class_act;
reg sd_act;
reg [5:0] vcxo_act;
reg [6:0] upconv_act;
reg [6:0] mod_act;
reg [5:0] bias_act;

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        vcxo_in <= `RFMDC_RST_CODE6;
        upconv_in <= `RFMDC_RST_CODE7;
        mod_in <= `RFMDC_RST_CODE7;
        bias_in <= `RFMDC_RST_CODE6;
        forward_in <= 1'b0;
        direct_in <= 1'b0;
        class_in <= `RFMDC_CLASS_1;
        mode_in <= `RFMDC_MODE_SHUTDOWN;
        sd_in <= 1'b0;
        load_pend <= 1'b0;
    end else begin
        load_pend <= frame_done & cmd[`RFMDC_CMD_LD_BIT];
        if (frame_done) begin
            mode_in <= {cmd[`RFMDC_CMD_RX_BIT], cmd[`RFMDC_CMD_TX_BIT]};
            sd_in <= cmd[`RFMDC_CMD_SD_BIT];
            if (cmd_addr == `RFMDC_ADDR_VCXO_TUNE) begin
                vcxo_in <= data[`RFMDC_D_CODE6_MSB:0];
            end else if (cmd_addr == `RFMDC_ADDR_UPCONV_GAIN) begin
                upconv_in <= data[`RFMDC_D_CODE7_MSB:0];
                forward_in <= data[`RFMDC_D_FLAG_BIT];
            end else if (cmd_addr == `RFMDC_ADDR_MOD_GAIN) begin
                mod_in <= data[`RFMDC_D_CODE7_MSB:0];
                direct_in <= data[`RFMDC_D_FLAG_BIT];
            end else if (cmd_addr == `RFMDC_ADDR_PA_BIAS) begin
                bias_in <= data[`RFMDC_D_CODE6_MSB:0];
                class_in <= data[`RFMDC_D_CLASS_MSB:`RFMDC_D_CLASS_LSB];
            end
            // Other addresses store only the mode and shutdown bits
        end
    end
end

// Transfer of every input register at once
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        vcxo_act <= `RFMDC_RST_CODE6;
        upconv_act <= `RFMDC_RST_CODE7;
        mod_act <= `RFMDC_RST_CODE7;
        bias_act <= `RFMDC_RST_CODE6;
        forward_act <= 1'b0;
        direct_channel_o <= 1'b0;
        class_act <= `RFMDC_CLASS_1;
        power_mode_o <= `RFMDC_MODE_SHUTDOWN;
        sd_act <= 1'b0;
    end else if (load_pend) begin
        vcxo_act <= vcxo_in;
        upconv_act <= upconv_in;
        mod_act <= mod_in;
        bias_act <= bias_in;
        forward_act <= forward_in;
        direct_channel_o <= direct_in;
        class_act <= class_in;
        power_mode_o <= mode_in;
        sd_act <= sd_in;
    end
end

// ----------------------------------------------------------------
// Power mode decode and DAC outputs
// ----------------------------------------------------------------
wire tx_mode = (power_mode_o == `RFMDC_MODE_TRANSMIT);
wire rx_mode = (power_mode_o == `RFMDC_MODE_RECEIVE);
reg [3:0] next_dac_en;

// Enable order: {pa_bias, modulator, upconv, vcxo}
always @* begin
    next_dac_en = 4'h0;
    case (power_mode_o)
        `RFMDC_MODE_TRANSMIT: next_dac_en = 4'hf;
        `RFMDC_MODE_RECEIVE: next_dac_en = 4'h5;
        `RFMDC_MODE_STANDBY: next_dac_en = 4'h9;
        default: next_dac_en = 4'h0;
    endcase
    next_dac_en[3] = next_dac_en[3] & sd_act;
end

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        dac_enable_o <= 4'h0;
        vcxo_tune_dac_o <= `RFMDC_RST_CODE6;
        upconv_gain_dac_o <= `RFMDC_RST_CODE7;
        modulator_gain_dac_o <= `RFMDC_RST_CODE7;
        pa_bias_dac_o <= `RFMDC_RST_CODE6;
        bias_gen_shutdown_out_n_o <= 1'b0;
    end else begin
        dac_enable_o <= next_dac_en;
        // A disabled DAC is pulled to zero
        vcxo_tune_dac_o <= next_dac_en[0] ? vcxo_act : `RFMDC_RST_CODE6;
        upconv_gain_dac_o <= next_dac_en[1] ? upconv_act : `RFMDC_RST_CODE7;
        modulator_gain_dac_o <= next_dac_en[2] ? mod_act : `RFMDC_RST_CODE7;
        pa_bias_dac_o <= next_dac_en[3] ? bias_act : `RFMDC_RST_CODE6;
        bias_gen_shutdown_out_n_o <= sd_act;
    end
end

// ----------------------------------------------------------------
// Power-sense path and converter control
// ----------------------------------------------------------------
wire path_on = mwin & (tx_mode | rx_mode);
wire class1 = (class_act == `RFMDC_CLASS_1);
reg [2:0] next_mux;
reg [2:0] next_gain;

// Mux {fwd class2-4, fwd class1, reverse}; gain {rev 2-4, rev 1, fwd}
always @* begin
    next_mux = 3'h0;
    next_gain = 3'h1;
    if (forward_act) begin
        next_mux = class1 ? 3'h2 : 3'h4;
        next_gain = 3'h1;
    end else begin
        next_mux = 3'h1;
        next_gain = class1 ? 3'h2 : 3'h4;
    end
end

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sense_path_power_o <= 1'b0;
        sense_amp_enable_o <= 1'b0;
        sense_bias_out_o <= 1'b0;
        sense_mux_sel_o <= 3'h0;
        sense_gain_sel_o <= 3'h1;
        peak_track_o <= 1'b0;
        conv_start_o <= 1'b0;
        converter_power_o <= 1'b0;
        conversion_result <= `RFMDC_RST_BYTE;
    end else begin
        sense_path_power_o <= path_on;
        sense_amp_enable_o <= path_on & tx_mode;
        sense_bias_out_o <= path_on & tx_mode;
        // Unselected inputs stay grounded
        sense_mux_sel_o <= (path_on & tx_mode) ? next_mux : 3'h0;
        sense_gain_sel_o <= next_gain;
        converter_power_o <= mctl & (tx_mode | rx_mode);
        // Conversion at window end releases the held peak
        conv_start_o <= mwin_fall & (tx_mode | rx_mode);
        if (path_on) begin
            peak_track_o <= 1'b1;
        end else if (conv_start_o) begin
            peak_track_o <= 1'b0;
        end
        if (conv_done_i) begin
            conversion_result <= conv_data_i;
        end
    end
end

// ----------------------------------------------------------------
// Antenna diversity
// ----------------------------------------------------------------
reg [4:0] div_cnt;

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        div_cnt <= 5'h00;
        diversity_circuit_power_o <= 1'b0;
        acquire_first_o <= 1'b0;
        acquire_second_o <= 1'b0;
        best_antenna_out_o <= 1'b0;
    end else begin
        // Control may only drop one clock after the window
        diversity_circuit_power_o <= dwin | dctl;
        if (dwin_rise) begin
            div_cnt <= 5'h00;
        end else if (dwin && sclk_rise && div_cnt != 5'h1f) begin
            div_cnt <= div_cnt + 5'h01;
        end
        // Control low/high phases come from the controller
        acquire_first_o <= dwin & dctl & (div_cnt <= {1'b0, `RFMDC_DIV_FIRST_PERIOD});
        acquire_second_o <= dwin & dctl & (div_cnt > {1'b0, `RFMDC_DIV_FIRST_PERIOD});
        if (dwin_fall) begin
            best_antenna_out_o <= compare_second_greater_i;
        end
    end
end

endmodule
`default_nettype wire

// ==== include/rfmdc_regs.vh ====
/*
 * Constants of the rf measure / DAC control block: serial frame layout,
 * data-byte map, power modes and diversity timing.
 * Assumes inclusion by the block's design file, the monitor and the bench.
 */
`ifndef RFMDC_REGS_VH
`define RFMDC_REGS_VH

// ----------------------------------------------------------------
// Data-byte map, by command address
// ----------------------------------------------------------------
`define RFMDC_ADDR_VCXO_TUNE 3'h0
`define RFMDC_ADDR_UPCONV_GAIN 3'h1
`define RFMDC_ADDR_MOD_GAIN 3'h2
`define RFMDC_ADDR_PA_BIAS 3'h3
`define RFMDC_ADDR_CONV_RESULT 3'h7

// ----------------------------------------------------------------
// Command byte fields (7 bits after the start bit, MSB first)
// ----------------------------------------------------------------
`define RFMDC_CMD_ADDR_MSB 6
`define RFMDC_CMD_ADDR_LSB 4
`define RFMDC_CMD_RX_BIT 3
`define RFMDC_CMD_TX_BIT 2
`define RFMDC_CMD_SD_BIT 1
`define RFMDC_CMD_LD_BIT 0
`define RFMDC_CMD_BITS 4'h7
`define RFMDC_DATA_BITS 4'h8

// ----------------------------------------------------------------
// Data byte fields
// ----------------------------------------------------------------
`define RFMDC_D_CODE6_MSB 5
`define RFMDC_D_CODE7_MSB 6
`define RFMDC_D_FLAG_BIT 7
`define RFMDC_D_CLASS_MSB 7
`define RFMDC_D_CLASS_LSB 6

// ----------------------------------------------------------------
// Power modes {receive_enable_bit, transmit_enable_bit}
// ----------------------------------------------------------------
`define RFMDC_MODE_SHUTDOWN 2'h0
`define RFMDC_MODE_TRANSMIT 2'h1
`define RFMDC_MODE_RECEIVE 2'h2
`define RFMDC_MODE_STANDBY 2'h3
`define RFMDC_CLASS_1 2'h0

// ----------------------------------------------------------------
// Reset values and diversity timing in serial clocks
// ----------------------------------------------------------------
`define RFMDC_RST_CODE6 6'h00
`define RFMDC_RST_CODE7 7'h00
`define RFMDC_RST_BYTE 8'h00
`define RFMDC_DIV_FIRST_PERIOD 4'hc

`endif
